/* shared/bbx_pkg.sv */
// Functional notes
// - branch target is instruction low 18 bits
// - taken branch jumps to target, else continue
// - indefinite branch on exponent 1777 or 6000
// - overflow and underflow operands do not jump
// - taken jump from stack voids whole stack
// - opcode 04 jumps on bitwise index equality
// - opcode 05 jumps on any index bit difference
// - opcode 06 jumps on signed greater or equal
// - opcode 07 jumps on signed strictly less
// - positive zero orders above negative zero
// - opcode 10 copies source word unchanged
// - opcode 11 writes bitwise and
// - opcode 12 writes bitwise inclusive or
// - opcode 13 writes bitwise exclusive or
// - opcode 14 writes complement of second source
// - opcode 15 writes first and not second
// - opcode 16 writes first or not second
// - index bit 17 is the sign bit
package bbx_pkg;

    localparam int XW       = 60;
    localparam int BW       = 18;
    localparam int AW       = 3;
    localparam int IW       = 30;
    localparam int OPW      = 6;
    localparam int EXPW     = 12;
    localparam int NREG     = 8;

    // field positions (lsb of each field)
    localparam int OP1_LSB  = 9;
    localparam int I1_LSB   = 6;
    localparam int J1_LSB   = 3;
    localparam int K1_LSB   = 0;
    localparam int OP2_LSB  = 24;
    localparam int I2_LSB   = 21;
    localparam int J2_LSB   = 18;
    localparam int K2_LSB   = 0;
    localparam int EXP_LSB  = 48;
    localparam int SIGN_BIT = 17;

    // opcodes (octal 03/7, 04..07, 10..16)
    localparam logic [OPW-1:0] OP_XGRP = 6'h03;
    localparam logic [AW-1:0]  SUB_IND = 3'h7;
    localparam logic [OPW-1:0] OP_BEQ  = 6'h04;
    localparam logic [OPW-1:0] OP_BNE  = 6'h05;
    localparam logic [OPW-1:0] OP_BGE  = 6'h06;
    localparam logic [OPW-1:0] OP_BLT  = 6'h07;
    localparam logic [OPW-1:0] OP_XMIT = 6'h08;
    localparam logic [OPW-1:0] OP_AND  = 6'h09;
    localparam logic [OPW-1:0] OP_OR   = 6'h0A;
    localparam logic [OPW-1:0] OP_XOR  = 6'h0B;
    localparam logic [OPW-1:0] OP_CPL  = 6'h0C;
    localparam logic [OPW-1:0] OP_ANDN = 6'h0D;
    localparam logic [OPW-1:0] OP_ORN  = 6'h0E;

    localparam logic [EXPW-1:0] EXP_IND_POS = 12'h3FF;
    localparam logic [EXPW-1:0] EXP_IND_NEG = 12'hC00;

    // reset values
    localparam logic [XW-1:0] X_RST  = 60'h0;
    localparam logic [BW-1:0] B_RST  = 18'h0;
    localparam logic [IW-1:0] IW_RST = 30'h0;
    localparam logic [AW-1:0] A_RST  = 3'h0;

    typedef enum logic [1:0] {
        BBX_IDLE,
        BBX_FETCH,
        BBX_EXEC
    } bbx_state_type;

    // flipping the sign turns one's-complement order into unsigned order,
    // and leaves -0 (3FFFF -> 1FFFF) just below +0 (00000 -> 20000)
    function automatic logic [BW-1:0] bbx_order_key(input logic [BW-1:0] v);
        bbx_order_key = {~v[SIGN_BIT], v[SIGN_BIT-1:0]};
    endfunction : bbx_order_key

    // only the two indefinite exponents match; overflow 3777/4000 does not
    function automatic logic bbx_is_indefinite(input logic [XW-1:0] v);
        logic [EXPW-1:0] e;
        e = v[EXP_LSB +: EXPW];
        bbx_is_indefinite = (e == EXP_IND_POS) || (e == EXP_IND_NEG);
    endfunction : bbx_is_indefinite

endpackage : bbx_pkg

/* shared/bbx_rf_if.sv */
`timescale 1ns/1ps
interface bbx_rf_if;
    logic [bbx_pkg::AW-1:0] xa_addr;
    logic [bbx_pkg::AW-1:0] xb_addr;
    logic [bbx_pkg::AW-1:0] ba_addr;
    logic [bbx_pkg::AW-1:0] bb_addr;
    logic [bbx_pkg::XW-1:0] xa_data;
    logic [bbx_pkg::XW-1:0] xb_data;
    logic [bbx_pkg::BW-1:0] ba_data;
    logic [bbx_pkg::BW-1:0] bb_data;
    logic                   x_we;
    logic [bbx_pkg::AW-1:0] x_waddr;
    logic [bbx_pkg::XW-1:0] x_wdata;

    modport exec (
        output xa_addr, xb_addr, ba_addr, bb_addr, x_we, x_waddr, x_wdata,
        input  xa_data, xb_data, ba_data, bb_data
    );
    modport store (
        input  xa_addr, xb_addr, ba_addr, bb_addr, x_we, x_waddr, x_wdata,
        output xa_data, xb_data, ba_data, bb_data
    );
endinterface : bbx_rf_if

/* core/bbx_regfile.sv */
`timescale 1ns/1ps
module bbx_regfile (
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    bbx_rf_if.store                     rf,
    input  wire logic                   x_load_en,
    input  wire logic [bbx_pkg::AW-1:0] x_load_addr,
    input  wire logic [bbx_pkg::XW-1:0] x_load_data,
    input  wire logic                   b_load_en,
    input  wire logic [bbx_pkg::AW-1:0] b_load_addr,
    input  wire logic [bbx_pkg::BW-1:0] b_load_data,
    input  wire logic [bbx_pkg::AW-1:0] peek_x_addr,
    output logic      [bbx_pkg::XW-1:0] peek_x_data,
    input  wire logic [bbx_pkg::AW-1:0] peek_b_addr,
    output logic      [bbx_pkg::BW-1:0] peek_b_data
);

    typedef struct packed {
        logic [bbx_pkg::NREG-1:0][bbx_pkg::XW-1:0] x;
        logic [bbx_pkg::NREG-1:0][bbx_pkg::BW-1:0] b;
        logic [bbx_pkg::XW-1:0]                    xa;
        logic [bbx_pkg::XW-1:0]                    xb;
        logic [bbx_pkg::BW-1:0]                    ba;
        logic [bbx_pkg::BW-1:0]                    bb;
        logic [bbx_pkg::XW-1:0]                    px;
        logic [bbx_pkg::BW-1:0]                    pb;
    } bbx_rf_state_type;

    bbx_rf_state_type cur;
    bbx_rf_state_type next_cur;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_cur    = cur;
        // reads see the old word; a same-cycle write shows one cycle later
        next_cur.xa = cur.x[rf.xa_addr];
        next_cur.xb = cur.x[rf.xb_addr];
        next_cur.ba = cur.b[rf.ba_addr];
        next_cur.bb = cur.b[rf.bb_addr];
        next_cur.px = cur.x[peek_x_addr];
        next_cur.pb = cur.b[peek_b_addr];
        if (x_load_en) begin
            next_cur.x[x_load_addr] = x_load_data;
        end
        // execution result wins over an external load to the same word
        if (rf.x_we) begin
            next_cur.x[rf.x_waddr] = rf.x_wdata;
        end
        if (b_load_en) begin
            next_cur.b[b_load_addr] = b_load_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rf.xa_data  = cur.xa;
    assign rf.xb_data  = cur.xb;
    assign rf.ba_data  = cur.ba;
    assign rf.bb_data  = cur.bb;
    assign peek_x_data = cur.px;
    assign peek_b_data = cur.pb;

endmodule : bbx_regfile

/* core/bbx_exec.sv */
`timescale 1ns/1ps
module bbx_exec (
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   issue_valid,
    input  wire logic [bbx_pkg::IW-1:0] issue_word,
    input  wire logic                   issue_two_parcel,
    input  wire logic                   issue_from_stack,
    input  wire logic                   stack_present,
    output logic                        issue_ready,
    output logic                        exec_done,
    output logic                        branch_taken,
    output logic                        branch_continue,
    output logic [bbx_pkg::BW-1:0]      branch_target,
    output logic                        stack_void,
    output logic                        op_unsupported,
    input  wire logic                   x_load_en,
    input  wire logic [bbx_pkg::AW-1:0] x_load_addr,
    input  wire logic [bbx_pkg::XW-1:0] x_load_data,
    input  wire logic                   b_load_en,
    input  wire logic [bbx_pkg::AW-1:0] b_load_addr,
    input  wire logic [bbx_pkg::BW-1:0] b_load_data,
    input  wire logic [bbx_pkg::AW-1:0] peek_x_addr,
    output logic      [bbx_pkg::XW-1:0] peek_x_data,
    input  wire logic [bbx_pkg::AW-1:0] peek_b_addr,
    output logic      [bbx_pkg::BW-1:0] peek_b_data
);

    typedef struct packed {
        bbx_pkg::bbx_state_type state;
        logic [bbx_pkg::IW-1:0] word;
        logic                   two_parcel;
        logic                   from_stack;
        logic                   has_stack;
        logic                   ready;
        logic                   done;
        logic                   taken;
        logic                   cont;
        logic [bbx_pkg::BW-1:0] target;
        logic                   void_stack;
        logic                   bad;
    } bbx_exec_state_type;

    bbx_exec_state_type cur;
    bbx_exec_state_type next_cur;

    bbx_rf_if rf ();

    bbx_regfile u_regfile (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .rf          (rf.store),
        .x_load_en   (x_load_en),
        .x_load_addr (x_load_addr),
        .x_load_data (x_load_data),
        .b_load_en   (b_load_en),
        .b_load_addr (b_load_addr),
        .b_load_data (b_load_data),
        .peek_x_addr (peek_x_addr),
        .peek_x_data (peek_x_data),
        .peek_b_addr (peek_b_addr),
        .peek_b_data (peek_b_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // instruction fields
    logic [bbx_pkg::OPW-1:0] op_short;
    logic [bbx_pkg::AW-1:0]  i_short;
    logic [bbx_pkg::AW-1:0]  j_short;
    logic [bbx_pkg::AW-1:0]  k_short;
    logic [bbx_pkg::OPW-1:0] op_long;
    logic [bbx_pkg::AW-1:0]  i_long;
    logic [bbx_pkg::AW-1:0]  j_long;
    logic [bbx_pkg::BW-1:0]  k_long;

    assign op_short = cur.word[bbx_pkg::OP1_LSB +: bbx_pkg::OPW];
    assign i_short  = cur.word[bbx_pkg::I1_LSB +: bbx_pkg::AW];
    assign j_short  = cur.word[bbx_pkg::J1_LSB +: bbx_pkg::AW];
    assign k_short  = cur.word[bbx_pkg::K1_LSB +: bbx_pkg::AW];
    assign op_long  = cur.word[bbx_pkg::OP2_LSB +: bbx_pkg::OPW];
    assign i_long   = cur.word[bbx_pkg::I2_LSB +: bbx_pkg::AW];
    assign j_long   = cur.word[bbx_pkg::J2_LSB +: bbx_pkg::AW];
    assign k_long   = cur.word[bbx_pkg::K2_LSB +: bbx_pkg::BW];

    // the indefinite test reads its operand through the first x port
    assign rf.xa_addr = cur.two_parcel ? j_long : j_short;
    assign rf.xb_addr = k_short;
    assign rf.ba_addr = i_long;
    assign rf.bb_addr = j_long;

    ////////////////////////////////////////////////////////////////////////
    // operand views and condition evaluation
    logic [bbx_pkg::XW-1:0] first_src_operand_reg;
    logic [bbx_pkg::XW-1:0] second_src_operand_reg;
    logic [bbx_pkg::BW-1:0] first_index_reg;
    logic [bbx_pkg::BW-1:0] second_index_reg;
    logic                   idx_equal;
    logic                   idx_ge;
    logic                   xind;

    assign first_src_operand_reg  = rf.xa_data;
    assign second_src_operand_reg = rf.xb_data;
    assign first_index_reg        = rf.ba_data;
    assign second_index_reg       = rf.bb_data;

    // bitwise, so 00000 and 3FFFF differ
    assign idx_equal = (first_index_reg == second_index_reg);
    assign idx_ge    = bbx_pkg::bbx_order_key(first_index_reg) >=
                       bbx_pkg::bbx_order_key(second_index_reg);
    assign xind      = bbx_pkg::bbx_is_indefinite(first_src_operand_reg);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic                   is_branch;
        logic                   cond;
        logic                   wr;
        logic [bbx_pkg::XW-1:0] res;
        is_branch = 1'b0;
        cond      = 1'b0;
        wr        = 1'b0;
        res       = bbx_pkg::X_RST;

        next_cur            = cur;
        next_cur.done       = 1'b0;
        next_cur.taken      = 1'b0;
        next_cur.cont       = 1'b0;
        next_cur.void_stack = 1'b0;
        next_cur.bad        = 1'b0;

        if (cur.two_parcel) begin
            unique case (op_long)
                bbx_pkg::OP_XGRP: begin
                    is_branch = (i_long == bbx_pkg::SUB_IND);
                    cond      = xind;
                end
                bbx_pkg::OP_BEQ: begin
                    is_branch = 1'b1;
                    cond      = idx_equal;
                end
                bbx_pkg::OP_BNE: begin
                    is_branch = 1'b1;
                    cond      = !idx_equal;
                end
                bbx_pkg::OP_BGE: begin
                    is_branch = 1'b1;
                    cond      = idx_ge;
                end
                bbx_pkg::OP_BLT: begin
                    is_branch = 1'b1;
                    cond      = !idx_ge;
                end
                default: begin
                    is_branch = 1'b0;
                end
            endcase
        end else begin
            wr = 1'b1;
            unique case (op_short)
                bbx_pkg::OP_XMIT: res = first_src_operand_reg;
                bbx_pkg::OP_AND:  res = first_src_operand_reg & second_src_operand_reg;
                bbx_pkg::OP_OR:   res = first_src_operand_reg | second_src_operand_reg;
                bbx_pkg::OP_XOR:  res = first_src_operand_reg ^ second_src_operand_reg;
                bbx_pkg::OP_CPL:  res = ~second_src_operand_reg;
                bbx_pkg::OP_ANDN: res = first_src_operand_reg & ~second_src_operand_reg;
                bbx_pkg::OP_ORN:  res = first_src_operand_reg | ~second_src_operand_reg;
                default: begin
                    wr = 1'b0;
                end
            endcase
        end

        rf.x_we    = 1'b0;
        rf.x_waddr = i_short;
        rf.x_wdata = res;

        unique case (cur.state)
            bbx_pkg::BBX_IDLE: begin
                if (issue_valid) begin
                    next_cur.state      = bbx_pkg::BBX_FETCH;
                    next_cur.word       = issue_word;
                    next_cur.two_parcel = issue_two_parcel;
                    next_cur.from_stack = issue_from_stack;
                    next_cur.has_stack  = stack_present;
                    next_cur.ready      = 1'b0;
                end
            end
            bbx_pkg::BBX_FETCH: begin
                // register file read data are registered; wait one cycle
                next_cur.state = bbx_pkg::BBX_EXEC;
            end
            bbx_pkg::BBX_EXEC: begin
                next_cur.state = bbx_pkg::BBX_IDLE;
                next_cur.ready = 1'b1;
                next_cur.done  = 1'b1;
                rf.x_we        = wr;
                if (is_branch) begin
                    next_cur.taken  = cond;
                    next_cur.cont   = !cond;
                    next_cur.target = k_long;
                    next_cur.void_stack = cond && cur.from_stack && cur.has_stack;
                end else begin
                    next_cur.bad = !wr;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cur            <= '0;
            cur.state      <= bbx_pkg::BBX_IDLE;
            cur.word       <= bbx_pkg::IW_RST;
            cur.target     <= bbx_pkg::B_RST;
            cur.ready      <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign issue_ready     = cur.ready;
    assign exec_done       = cur.done;
    assign branch_taken    = cur.taken;
    assign branch_continue = cur.cont;
    assign branch_target   = cur.target;
    assign stack_void      = cur.void_stack;
    assign op_unsupported  = cur.bad;

endmodule : bbx_exec

/* bench/bbx_checker.sv */
`timescale 1ns/1ps
module bbx_checker (
    input wire logic                   ref_clk,
    input wire logic                   rstn,
    input wire logic                   issue_valid,
    input wire logic [bbx_pkg::IW-1:0] issue_word,
    input wire logic                   issue_two_parcel,
    input wire logic                   issue_from_stack,
    input wire logic                   stack_present,
    input wire logic                   issue_ready,
    input wire logic                   exec_done,
    input wire logic                   branch_taken,
    input wire logic                   branch_continue,
    input wire logic [bbx_pkg::BW-1:0] branch_target,
    input wire logic                   stack_void,
    input wire logic                   op_unsupported
);
    logic acc;
    logic acc_br;
    assign acc    = issue_valid && issue_ready;
    // index compare branches are opcodes 04..07
    assign acc_br = acc && issue_two_parcel && (issue_word[29:26] == 4'h1);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////
    property p_answer;
        acc |=> (!issue_ready && !exec_done) [*2] ##1 (exec_done && issue_ready);
    endproperty
    a_answer: assert property (p_answer) else $error("answer not in cycle 3");
    property p_outcome;
        acc_br |-> ##3 (branch_taken ^ branch_continue);
    endproperty
    a_outcome: assert property (p_outcome) else $error("branch outcome not unique");
    property p_target;
        acc_br |-> ##3 (branch_target == $past(issue_word[17:0], 3));
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");
    property p_target_hold;
        (!exec_done && $past(rstn)) |-> $stable(branch_target);
    endproperty
    a_target_hold: assert property (p_target_hold) else $error("target moved");
    property p_void_taken;
        stack_void |-> (branch_taken && exec_done);
    endproperty
    a_void_taken: assert property (p_void_taken) else $error("void without jump");
    property p_void_cause;
        (acc_br && issue_from_stack && stack_present) |-> ##3 (stack_void == branch_taken);
    endproperty
    a_void_cause: assert property (p_void_cause) else $error("stack not voided");
    property p_void_none;
        (acc && !(issue_from_stack && stack_present)) |-> ##3 !stack_void;
    endproperty
    a_void_none: assert property (p_void_none) else $error("stray stack void");
    property p_short;
        (acc && !issue_two_parcel) |-> ##3 (!branch_taken && !branch_continue);
    endproperty
    a_short: assert property (p_short) else $error("short word branched");
    property p_unsup;
        (acc && !issue_two_parcel && (issue_word[14:9] < bbx_pkg::OP_XMIT
            || issue_word[14:9] > bbx_pkg::OP_ORN)) |-> ##3 op_unsupported;
    endproperty
    a_unsup: assert property (p_unsup) else $error("foreign opcode not flagged");
    property p_pulse;
        exec_done |=> !exec_done;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
endmodule : bbx_checker

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic        br;
        logic        tk;
        logic        vd;
        logic        un;
        logic        cx;
        logic [2:0]  xa;
        logic [17:0] tg;
        logic [59:0] xv;
    } bbx_note_type;

    logic         ref_clk = 1'b0;
    logic         rstn = 1'b0;
    logic         issue_valid = 1'b0;
    logic [29:0]  issue_word = 30'h0;
    logic         issue_two_parcel = 1'b0;
    logic         issue_from_stack = 1'b0;
    logic         stack_present = 1'b0;
    logic         x_load_en = 1'b0;
    logic [2:0]   x_load_addr = 3'h0;
    logic [59:0]  x_load_data = 60'h0;
    logic         b_load_en = 1'b0;
    logic [2:0]   b_load_addr = 3'h0;
    logic [17:0]  b_load_data = 18'h0;
    logic [2:0]   peek_x_addr = 3'h0;
    logic [2:0]   peek_b_addr = 3'h2;
    logic         issue_ready, exec_done, branch_taken, branch_continue;
    logic         stack_void, op_unsupported;
    logic [17:0]  branch_target, peek_b_data;
    logic [59:0]  peek_x_data;
    int           fail_count = 0;
    int           tests_run = 0;
    integer       seed = 32'h3C34;
    bbx_note_type q[$];

    bbx_exec uut (.ref_clk(ref_clk), .rstn(rstn), .issue_valid(issue_valid),
        .issue_word(issue_word), .issue_two_parcel(issue_two_parcel),
        .issue_from_stack(issue_from_stack), .stack_present(stack_present),
        .issue_ready(issue_ready), .exec_done(exec_done), .branch_taken(branch_taken),
        .branch_continue(branch_continue), .branch_target(branch_target),
        .stack_void(stack_void), .op_unsupported(op_unsupported), .x_load_en(x_load_en),
        .x_load_addr(x_load_addr), .x_load_data(x_load_data), .b_load_en(b_load_en),
        .b_load_addr(b_load_addr), .b_load_data(b_load_data), .peek_x_addr(peek_x_addr),
        .peek_x_data(peek_x_data), .peek_b_addr(peek_b_addr), .peek_b_data(peek_b_data));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one's-complement order as unsigned: sign flipped keeps -0 just under +0
    function automatic logic [17:0] okey(input logic [17:0] v);
        okey = {~v[17], v[16:0]};
    endfunction : okey

    // loads end one idle cycle later so an enable never toggles twice at once
    task automatic load_x(input logic [2:0] a, input logic [59:0] d);
        x_load_en = 1'b1;
        x_load_addr = a;
        x_load_data = d;
        @(negedge ref_clk);
        x_load_en = 1'b0;
        @(negedge ref_clk);
    endtask : load_x

    task automatic load_b(input logic [2:0] a, input logic [17:0] d);
        b_load_en = 1'b1;
        b_load_addr = a;
        b_load_data = d;
        @(negedge ref_clk);
        b_load_en = 1'b0;
        @(negedge ref_clk);
    endtask : load_b

    task automatic issue(input logic tp, input logic [29:0] w, input bbx_note_type n,
                         input int gap);
        logic fs;
        logic sp;
        fs = 1'($random(seed));
        sp = 1'($random(seed));
        n.vd = n.tk & fs & sp;
        issue_valid = 1'b1;
        issue_two_parcel = tp;
        issue_word = w;
        issue_from_stack = fs;
        stack_present = sp;
        q.push_back(n);
        @(negedge ref_clk);
        issue_valid = 1'b0;
        repeat (gap) @(negedge ref_clk);
    endtask : issue

    task automatic br_idx(input logic [5:0] op, input logic [17:0] a, input logic [17:0] b);
        logic [17:0] t;
        logic        tk;
        t = 18'($random(seed));
        load_b(3'h2, a);
        load_b(3'h5, b);
        case (op)
            bbx_pkg::OP_BEQ: tk = (a === b);
            bbx_pkg::OP_BNE: tk = (a !== b);
            bbx_pkg::OP_BGE: tk = (okey(a) >= okey(b));
            default:         tk = (okey(a) < okey(b));
        endcase
        issue(1'b1, {op, 6'o25, t}, '{1'b1, tk, 1'b0, 1'b0, 1'b0, 3'h0, t, 60'h0}, 2);
    endtask : br_idx

    task automatic br_ind(input logic [11:0] e, input logic [2:0] i);
        logic [59:0] x;
        logic [17:0] t;
        logic        tk;
        x = 60'({$random(seed), $random(seed)});
        x[59:48] = e;
        t = 18'($random(seed));
        load_x(3'h4, x);
        tk = (i == 3'h7) && (e == 12'h3FF || e == 12'hC00);
        issue(1'b1, {bbx_pkg::OP_XGRP, i, 3'h4, t},
              '{i == 3'h7, tk, 1'b0, i != 3'h7, 1'b0, 3'h0, t, 60'h0}, 2);
    endtask : br_ind

    task automatic bool_op(input logic [5:0] op, input logic [59:0] a, input logic [59:0] b);
        logic [59:0] r;
        logic [2:0]  i;
        logic        un;
        i = 3'($random(seed));
        un = 1'b0;
        r = 60'h0;
        load_x(3'h1, a);
        load_x(3'h2, b);
        case (op)
            bbx_pkg::OP_XMIT: r = a;
            bbx_pkg::OP_AND:  r = a & b;
            bbx_pkg::OP_OR:   r = a | b;
            bbx_pkg::OP_XOR:  r = a ^ b;
            bbx_pkg::OP_CPL:  r = ~b;
            bbx_pkg::OP_ANDN: r = a & ~b;
            bbx_pkg::OP_ORN:  r = a | ~b;
            default:          un = 1'b1;
        endcase
        issue(1'b0, {15'h0, op, i, 6'o12}, '{1'b0, 1'b0, 1'b0, un, !un, i, 18'h0, r}, 3);
    endtask : bool_op

    ////////////////////////////////////////////////////////////////////////////
    // an unexpected done finds the queue empty and fails
    always @(negedge ref_clk) begin
        bbx_note_type n;
        if (rstn && exec_done === 1'b1) begin
            if (q.size() == 0) begin
                chk(1'b1, 1'b0);
            end else begin
                n = q.pop_front();
                chk({branch_taken, branch_continue, stack_void, op_unsupported},
                    {n.tk, n.br & ~n.tk, n.vd, n.un});
                if (n.br) chk(branch_target, n.tg);
                if (n.cx) begin
                    peek_x_addr = n.xa;
                    @(negedge ref_clk);
                    chk(peek_x_data, n.xv);
                end
            end
        end
    end

    initial begin
        #(8 * 20000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        logic [11:0] exps[7];
        exps = '{12'h3FF, 12'hC00, 12'h7FF, 12'h800, 12'h000, 12'hFFF, 12'h3FE};
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        chk({issue_ready, exec_done, branch_target, peek_b_data}, {2'b10, 36'h0});
        $display("reset test done");
        for (logic [5:0] op = 6'h04; op <= 6'h07; op++) begin
            br_idx(op, 18'h00000, 18'h3FFFF);
            br_idx(op, 18'h3FFFF, 18'h00000);
            br_idx(op, 18'h1FFFF, 18'h20000);
            br_idx(op, 18'h20000, 18'h1FFFF);
            br_idx(op, 18'h0ABCD, 18'h0ABCD);
            repeat (4) br_idx(op, 18'($random(seed)), 18'($random(seed)));
        end
        $display("index branch test done");
        foreach (exps[e]) br_ind(exps[e], 3'h7);
        br_ind(12'h3FF, 3'h3);
        $display("indefinite test done");
        for (logic [5:0] op = 6'h08; op <= 6'h0F; op++) begin
            repeat (3) bool_op(op, 60'({$random(seed), $random(seed)}),
                               60'({$random(seed), $random(seed)}));
        end
        $display("boolean test done");
        // long word with an opcode outside this block
        issue(1'b1, {6'h02, 6'o25, 18'h03333},
              '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 18'h0, 60'h0}, 2);
        load_b(3'h2, 18'h00123);
        load_b(3'h5, 18'h00123);
        chk(peek_b_data, 18'h00123);
        issue(1'b1, {bbx_pkg::OP_BEQ, 6'o25, 18'h0ABCD},
              '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 18'h0ABCD, 60'h0}, 2);
        issue(1'b1, {bbx_pkg::OP_BNE, 6'o25, 18'h01111},
              '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 18'h01111, 60'h0}, 1);
        // busy cycle: this request must be dropped, not queued
        issue_valid = 1'b1;
        issue_word = {bbx_pkg::OP_BEQ, 6'o25, 18'h02222};
        @(negedge ref_clk);
        issue_valid = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(q.size(), 0);
        $display("back to back and refusal test done");
        report_and_stop();
    end
endmodule : testbench

bind bbx_exec bbx_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .issue_valid(issue_valid),
    .issue_word(issue_word), .issue_two_parcel(issue_two_parcel),
    .issue_from_stack(issue_from_stack), .stack_present(stack_present),
    .issue_ready(issue_ready), .exec_done(exec_done), .branch_taken(branch_taken),
    .branch_continue(branch_continue), .branch_target(branch_target),
    .stack_void(stack_void), .op_unsupported(op_unsupported));
